// ===== rtl/uvmon_params.svh
`ifndef UVMON_PARAMS_SVH
`define UVMON_PARAMS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define UVMON_MODE_ADDR 32'hFFFFF890
`define UVMON_THR_ADDR 32'hFFFFF894
`define UVMON_PROT_ADDR 32'hFFFFF898
`define UVMON_STAT_ADDR 32'hFFFFF89C
`define UVMON_MASK_ADDR 32'hFFFFF8A0
`define UVMON_CAUSE_ADDR 32'hFFFFF8A4

// ************************************************************
// Field positions
// ************************************************************
`define UVMON_EN_BIT 7
`define UVMON_MD_BIT 1
`define UVMON_FLAG_BIT 0
`define UVMON_EV_UV_BIT 0
`define UVMON_EV_PROT_BIT 1

// ************************************************************
// Reset values and codes
// ************************************************************
`define UVMON_MODE_RST 8'h00
`define UVMON_THR_RST 3'h0
`define UVMON_MASK_RST 2'h3
`define UVMON_CAUSE_RST 1'h0
`define UVMON_THR_MAX 3'h6
`define UVMON_KEY 8'hA5

`endif

// ===== rtl/uvmon_pkg.sv
package uvmon_pkg;
  typedef logic [31:0] uvmon_addr_t;
  typedef logic [31:0] uvmon_word_t;
  typedef logic [2:0] uvmon_code_t;
  typedef enum logic [1:0] {LOCK_OPEN, LOCK_HELD, LOCK_SPENT} uvmon_lock_t;
  typedef enum logic {PROT_IDLE, PROT_ARMED} uvmon_prot_t;
endpackage

// ===== rtl/uvmon_sync.sv
`timescale 1ns/1ps
`default_nettype none

module uvmon_sync (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // uvmon_sync

`default_nettype wire

// ===== rtl/uvmon_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "uvmon_params.svh"

module uvmon_irq (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [1:0] i_event,
  input wire logic [1:0] i_clear,
  input wire logic i_mask_wr,
  input wire logic [1:0] i_mask_data,
  output logic [1:0] o_status,
  output logic [1:0] o_mask,
  output logic o_irq
);
  wire logic [1:0] next_status = (o_status & ~i_clear) | i_event;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_status <= 2'h0;
      o_mask <= `UVMON_MASK_RST;
    end else begin
      o_status <= next_status;
      if (i_mask_wr) begin
        o_mask <= i_mask_data;
      end
    end
  end

  assign o_irq = |(o_status & ~o_mask);
endmodule // uvmon_irq

`default_nettype wire

// ===== rtl/uvmon_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "uvmon_params.svh"

module uvmon_ctrl
  import uvmon_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_stop_mode,
  input wire logic i_below_threshold,
  input wire uvmon_pkg::uvmon_addr_t i_addr,
  input wire uvmon_pkg::uvmon_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bit_en,
  input wire logic [2:0] i_bit_sel,
  output uvmon_pkg::uvmon_word_t o_rdata,
  output uvmon_pkg::uvmon_code_t o_threshold_code,
  output logic o_comparator_enable,
  output logic o_undervoltage_irq,
  output logic o_undervoltage_reset,
  output logic o_undervoltage_reset_cause_flag,
  output logic o_irq
);
  import uvmon_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  logic monitor_enable_bit;
  logic reset_mode_bit;
  logic below_sync;
  logic [1:0] en_settle;
  logic uv_irq_q;
  logic uv_rst_q;
  uvmon_lock_t lock_state;
  uvmon_lock_t next_lock;
  uvmon_prot_t prot_state;
  uvmon_prot_t next_prot;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // ************************************************************
  // Comparator input
  // ************************************************************
  // Free running on i_mclk; STOP does not gate it
  uvmon_sync u_sync (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_async(i_below_threshold),
    .o_sync(below_sync)
  );

  // Hide synchroniser contents taken while the comparator was off
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_settle <= 2'h0;
    end else begin
      en_settle <= {en_settle[0], monitor_enable_bit};
    end
  end

  wire logic below_threshold_flag = monitor_enable_bit & en_settle[1] & below_sync;
  wire logic stop_seen = i_stop_mode;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire logic hit_mode = (i_addr == `UVMON_MODE_ADDR);
  wire logic hit_thr = (i_addr == `UVMON_THR_ADDR);
  wire logic hit_prot = (i_addr == `UVMON_PROT_ADDR);
  wire logic hit_stat = (i_addr == `UVMON_STAT_ADDR);
  wire logic hit_mask = (i_addr == `UVMON_MASK_ADDR);
  wire logic hit_cause = (i_addr == `UVMON_CAUSE_ADDR);
  wire logic key_wr = i_wr & hit_prot & (i_wdata[7:0] == `UVMON_KEY);
  wire logic mode_wr = i_wr & hit_mode;
  wire logic armed = monitor_enable_bit & reset_mode_bit;
  wire logic locked = (lock_state == LOCK_HELD) | ((lock_state == LOCK_OPEN) & armed);
  wire logic mode_wr_ok = mode_wr & (prot_state == PROT_ARMED) & ~locked;
  wire logic prot_fault = mode_wr & (prot_state != PROT_ARMED);
  wire logic [7:0] mode_image = {monitor_enable_bit, 5'h00, reset_mode_bit,
                                 below_threshold_flag};

  // ************************************************************
  // Byte or single bit write image
  // ************************************************************
  logic [7:0] write_image;
  always_comb begin
    write_image = i_wdata[7:0];
    if (i_bit_en) begin
      write_image = mode_image;
      write_image[i_bit_sel] = i_wdata[0];
    end
  end

  // Bits 6..2 and the flag are not stored, so writes to them vanish
  wire logic next_en = write_image[`UVMON_EN_BIT] |
                       (monitor_enable_bit & reset_mode_bit);
  wire logic next_md = write_image[`UVMON_MD_BIT];

  wire logic [2:0] thr_wcode = i_wdata[2:0];
  wire logic thr_wr_ok = i_wr & hit_thr & ~locked & (thr_wcode <= `UVMON_THR_MAX);

  // ************************************************************
  // Mode and threshold registers
  // ************************************************************
  // Only i_resetn, the other reset sources, clears these
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      monitor_enable_bit <= 1'(`UVMON_MODE_RST >> `UVMON_EN_BIT);
      reset_mode_bit <= 1'b0;
    end else if (mode_wr_ok) begin
      monitor_enable_bit <= next_en;
      reset_mode_bit <= next_md;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_threshold_code <= `UVMON_THR_RST;
    end else if (thr_wr_ok) begin
      o_threshold_code <= thr_wcode;
    end
  end

  // ************************************************************
  // Write protection
  // ************************************************************
  // Unlock holds for the very next strobe only
  always_comb begin
    next_prot = prot_state;
    case (prot_state)
      PROT_IDLE: begin
        if (key_wr) begin
          next_prot = PROT_ARMED;
        end
      end
      PROT_ARMED: begin
        if (i_wr | i_rd) begin
          next_prot = key_wr ? PROT_ARMED : PROT_IDLE;
        end
      end
      default: next_prot = PROT_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      prot_state <= PROT_IDLE;
    end else begin
      prot_state <= next_prot;
    end
  end

  // ************************************************************
  // Lock of the reset mode setting
  // ************************************************************
  wire logic uv_rst_rise = o_undervoltage_reset & ~uv_rst_q;

  always_comb begin
    next_lock = lock_state;
    case (lock_state)
      LOCK_OPEN: begin
        if (armed) begin
          next_lock = LOCK_HELD;
        end
      end
      LOCK_HELD: begin
        if (uv_rst_rise) begin
          next_lock = LOCK_SPENT;
        end
      end
      LOCK_SPENT: begin
        if (!armed) begin
          next_lock = LOCK_OPEN;
        end
      end
      default: next_lock = LOCK_OPEN;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_state <= LOCK_OPEN;
    end else begin
      lock_state <= next_lock;
    end
  end

  // ************************************************************
  // Detection outputs
  // ************************************************************
  assign o_comparator_enable = monitor_enable_bit;
  assign o_undervoltage_irq = below_threshold_flag & ~reset_mode_bit;
  assign o_undervoltage_reset = below_threshold_flag & reset_mode_bit;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      uv_irq_q <= 1'b0;
      uv_rst_q <= 1'b0;
    end else begin
      uv_irq_q <= o_undervoltage_irq;
      uv_rst_q <= o_undervoltage_reset;
    end
  end

  // ************************************************************
  // Reset cause flag
  // ************************************************************
  wire logic cause_clr = i_wr & hit_cause & i_wdata[0];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_undervoltage_reset_cause_flag <= `UVMON_CAUSE_RST;
    end else if (uv_rst_rise) begin
      o_undervoltage_reset_cause_flag <= 1'b1;
    end else if (cause_clr) begin
      o_undervoltage_reset_cause_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  wire logic [1:0] ev_vec;
  assign ev_vec[`UVMON_EV_UV_BIT] = o_undervoltage_irq & ~uv_irq_q;
  assign ev_vec[`UVMON_EV_PROT_BIT] = prot_fault;
  wire logic [1:0] stat_clr = (i_wr & hit_stat) ? i_wdata[1:0] : 2'h0;

  uvmon_irq u_irq (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_event(ev_vec),
    .i_clear(stat_clr),
    .i_mask_wr(i_wr & hit_mask),
    .i_mask_data(i_wdata[1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  // ************************************************************
  // Read path
  // ************************************************************
  wire logic [7:0] read_sel =
    hit_mode ? mode_image :
    hit_thr ? {5'h00, o_threshold_code} :
    hit_stat ? {6'h00, irq_status} :
    hit_mask ? {6'h00, irq_mask} :
    hit_cause ? {7'h00, o_undervoltage_reset_cause_flag} :
    8'h00;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= i_rd ? {24'h000000, read_sel} : 32'h00000000;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_irq_mirror;
    below_threshold_flag && !reset_mode_bit |-> o_undervoltage_irq;
  endproperty
  a_irq_mirror: assert property (p_irq_mirror)
    else $error("irq request does not follow flag");

  property p_rst_out;
    below_threshold_flag && reset_mode_bit
      |-> o_undervoltage_reset && !o_undervoltage_irq;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("reset request missing in reset mode");

  property p_flag_off;
    !monitor_enable_bit |-> !mode_image[`UVMON_FLAG_BIT] && !o_undervoltage_reset;
  endproperty
  a_flag_off: assert property (p_flag_off)
    else $error("flag set while disabled");

  property p_settle;
    $rose(monitor_enable_bit) |-> !below_threshold_flag;
  endproperty
  a_settle: assert property (p_settle)
    else $error("stale comparator value shown after enable");

  property p_lock;
    locked && mode_wr |=> $stable(reset_mode_bit) && $stable(monitor_enable_bit);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked mode register changed");

  property p_prot;
    mode_wr && prot_state == PROT_IDLE |=> $stable(reset_mode_bit) && irq_status[1];
  endproperty
  a_prot: assert property (p_prot)
    else $error("unprotected write took effect");

  property p_cause;
    $rose(o_undervoltage_reset) |=> o_undervoltage_reset_cause_flag;
  endproperty
  a_cause: assert property (p_cause)
    else $error("reset cause flag not set");

  property p_code;
    o_threshold_code <= `UVMON_THR_MAX;
  endproperty
  a_code: assert property (p_code)
    else $error("prohibited threshold code stored");

  property p_sync;
    $rose(below_threshold_flag) && $stable(monitor_enable_bit)
      |-> $past(i_below_threshold, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("flag rose without two stage delay");

  property p_nostop;
    monitor_enable_bit && reset_mode_bit |=> monitor_enable_bit;
  endproperty
  a_nostop: assert property (p_nostop)
    else $error("armed detection was stopped");

  property p_read_mode;
    i_rd && hit_mode |=> o_rdata[7:0] == {$past(monitor_enable_bit), 5'h00,
      $past(reset_mode_bit), $past(below_threshold_flag)};
  endproperty
  a_read_mode: assert property (p_read_mode)
    else $error("mode register read layout wrong");

  c_reset_fired: cover property ($rose(o_undervoltage_reset));
  c_irq_pending: cover property (o_irq && irq_status[0]);
  c_locked_write: cover property (locked && mode_wr);
  c_bit_write: cover property (mode_wr_ok && i_bit_en);
  c_stop_detect: cover property (stop_seen && below_threshold_flag);
endmodule // uvmon_ctrl

`default_nettype wire

// ===== tb/uvmon_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Supply comparator model
// ************************************************************
module uvmon_supply_model (
  input wire logic i_mclk,
  input wire logic i_enable,
  input wire uvmon_pkg::uvmon_code_t i_code,
  input wire logic [2:0] i_supply,
  output logic o_below
);
  import uvmon_pkg::*;

  logic junk = 1'b0;

  // Comparator off: output wanders
  always @(posedge i_mclk) begin
    junk <= ~junk;
  end

  // Higher code trips at a lower supply
  assign o_below = i_enable ? (i_supply < (3'h7 - i_code)) : junk;
endmodule // uvmon_supply_model

`default_nettype wire

// ===== tb/supply_undervoltage_monitor_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uvmon_params.svh"

module supply_undervoltage_monitor_ctrl_tb;
  import uvmon_pkg::*;

  logic i_mclk, i_resetn, stop, below, wr_strobe, rd_strobe, bit_en;
  logic cmp_en, urq, urst, cause, irq;
  logic [2:0] bit_sel, supply;
  uvmon_addr_t addr;
  uvmon_word_t wdata, rdata;
  uvmon_code_t code;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  uvmon_ctrl uvmon_ctrl_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_stop_mode(stop),
    .i_below_threshold(below), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_strobe),
    .i_rd(rd_strobe), .i_bit_en(bit_en), .i_bit_sel(bit_sel), .o_rdata(rdata),
    .o_threshold_code(code), .o_comparator_enable(cmp_en), .o_undervoltage_irq(urq),
    .o_undervoltage_reset(urst), .o_undervoltage_reset_cause_flag(cause), .o_irq(irq));

  uvmon_supply_model uvmon_supply_model_inst (.i_mclk(i_mclk), .i_enable(cmp_en),
    .i_code(code), .i_supply(supply), .o_below(below));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input uvmon_word_t exp, input uvmon_word_t act);
    n_tests++;
    if (act !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic reg_wr(input uvmon_addr_t a, input uvmon_word_t d, input logic be = 1'b0,
                        input logic [2:0] s = 3'h0);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    bit_en <= be;
    bit_sel <= s;
    wr_strobe <= 1'b1;
    @(posedge i_mclk);
    wr_strobe <= 1'b0;
    bit_en <= 1'b0;
  endtask

  task automatic rchk(input string n, input uvmon_addr_t a, input uvmon_word_t e);
    @(posedge i_mclk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge i_mclk);
    rd_strobe <= 1'b0;
    #1 chk(n, e, rdata);
  endtask

  // Protected write: key, then the mode access
  task automatic pw(input uvmon_word_t d, input logic be, input logic [2:0] s);
    reg_wr(`UVMON_PROT_ADDR, 32'hA5);
    reg_wr(`UVMON_MODE_ADDR, d, be, s);
  endtask

  task automatic step(input logic [2:0] s, input logic e_irq, input logic e_rst);
    logic oi, orr;
    #1;
    oi = urq;
    orr = urst;
    @(posedge i_mclk);
    supply <= s;
    @(posedge i_mclk);
    #1 chk("irq sync", oi, urq);
    chk("reset sync", orr, urst);
    @(posedge i_mclk);
    #1 chk("irq", e_irq, urq);
    chk("reset", e_rst, urst);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rchk("mode", `UVMON_MODE_ADDR, 32'h0);
    rchk("threshold", `UVMON_THR_ADDR, 32'h0);
    rchk("mask", `UVMON_MASK_ADDR, 32'h3);
    rchk("cause", `UVMON_CAUSE_ADDR, 32'h0);
    rchk("unmapped", 32'hFFFFF8B0, 32'h0);
  endtask

  task automatic t_protect();
    reg_wr(`UVMON_MODE_ADDR, 32'h80);
    rchk("unprotected", `UVMON_MODE_ADDR, 32'h0);
    rchk("fault", `UVMON_STAT_ADDR, 32'h2);
    reg_wr(`UVMON_STAT_ADDR, 32'h2);
    rchk("fault clear", `UVMON_STAT_ADDR, 32'h0);
    pw(32'h81, 1'b0, 3'h0);
    rchk("mode byte", `UVMON_MODE_ADDR, 32'h80);
    chk("enable out", 1'b1, cmp_en);
    pw(32'h0, 1'b1, 3'h7);
    rchk("bit clear", `UVMON_MODE_ADDR, 32'h0);
    pw(32'h1, 1'b1, 3'h7);
    rchk("bit set", `UVMON_MODE_ADDR, 32'h80);
    pw(32'h0, 1'b0, 3'h0);
  endtask

  task automatic t_levels();
    reg_wr(`UVMON_THR_ADDR, 32'h7);
    rchk("code 7", `UVMON_THR_ADDR, 32'h0);
    for (int c = 0; c < 7; c++) begin
      reg_wr(`UVMON_THR_ADDR, uvmon_word_t'(c));
      rchk("code", `UVMON_THR_ADDR, uvmon_word_t'(c));
      chk("code out", uvmon_word_t'(c), uvmon_word_t'(code));
    end
  endtask

  task automatic t_irq();
    reg_wr(`UVMON_THR_ADDR, 32'h3);
    stop <= 1'b1;
    pw(32'h80, 1'b0, 3'h0);
    step(3'h5, 1'b0, 1'b0);
    step(3'h2, 1'b1, 1'b0);
    rchk("flag", `UVMON_MODE_ADDR, 32'h81);
    rchk("status", `UVMON_STAT_ADDR, 32'h1);
    chk("masked", 1'b0, irq);
    reg_wr(`UVMON_MASK_ADDR, 32'h2);
    #1 chk("unmasked", 1'b1, irq);
    step(3'h5, 1'b0, 1'b0);
    rchk("sticky", `UVMON_STAT_ADDR, 32'h1);
    reg_wr(`UVMON_STAT_ADDR, 32'h1);
    #1 chk("cleared", 1'b0, irq);
    step(3'h2, 1'b1, 1'b0);
    pw(32'h0, 1'b0, 3'h0);
    repeat (3) @(posedge i_mclk);
    #1 chk("irq off", 1'b0, urq);
    rchk("flag off", `UVMON_MODE_ADDR, 32'h0);
    supply <= 3'h5;
    reg_wr(`UVMON_STAT_ADDR, 32'h1);
    reg_wr(`UVMON_MASK_ADDR, 32'h3);
  endtask

  task automatic t_lock();
    pw(32'h80, 1'b0, 3'h0);
    step(3'h5, 1'b0, 1'b0);
    pw(32'h82, 1'b0, 3'h0);
    pw(32'h0, 1'b0, 3'h0);
    rchk("locked mode", `UVMON_MODE_ADDR, 32'h82);
    reg_wr(`UVMON_THR_ADDR, 32'h1);
    rchk("locked code", `UVMON_THR_ADDR, 32'h3);
    step(3'h2, 1'b0, 1'b1);
    rchk("cause", `UVMON_CAUSE_ADDR, 32'h1);
    chk("cause out", 1'b1, cause);
    reg_wr(`UVMON_CAUSE_ADDR, 32'h1);
    rchk("cause clear", `UVMON_CAUSE_ADDR, 32'h0);
    rchk("kept", `UVMON_MODE_ADDR, 32'h83);
    step(3'h5, 1'b0, 1'b0);
    pw(32'h2, 1'b0, 3'h0);
    rchk("no stop", `UVMON_MODE_ADDR, 32'h82);
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rchk("mode cleared", `UVMON_MODE_ADDR, 32'h0);
    rchk("code cleared", `UVMON_THR_ADDR, 32'h0);
    chk("enable cleared", 1'b0, cmp_en);
  endtask

  // ************************************************************
  // Run and watchdog
  // ************************************************************
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    i_resetn = 1'b0;
    stop = 1'b0;
    supply = 3'h7;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    bit_en = 1'b0;
    bit_sel = 3'h0;
    addr = 32'h0;
    wdata = 32'h0;
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset();
    t_protect();
    t_levels();
    t_irq();
    t_lock();
    wrap_up();
  end
endmodule // supply_undervoltage_monitor_ctrl_tb

`default_nettype wire
